// >>> pkg/rsd_pkg.sv
// Constants and types shared by the reset source detection block.
`default_nettype none
package rsd_pkg;
   // Register offsets on the plain register port.
   localparam logic [2:0] RSD_OFS_CAUSE   = 3'h0;
   localparam logic [2:0] RSD_OFS_LVCTRL  = 3'h1;
   localparam logic [2:0] RSD_OFS_WDCS    = 3'h2;
   localparam logic [2:0] RSD_OFS_WDCNT   = 3'h3;
   localparam logic [2:0] RSD_OFS_WDCKS   = 3'h4;

   // Reset cause codes as read from the flag register.
   localparam logic [7:0] RSD_CAUSE_PWR   = 8'h02;
   localparam logic [7:0] RSD_CAUSE_EXT   = 8'h00;
   localparam logic [7:0] RSD_CAUSE_WDT   = 8'h01;
   localparam int         RSD_POWERON_LOWVOLT_FLAG_BIT    = 1;
   localparam int         RSD_WATCHDOG_RESET_FLAG_BIT    = 0;

   // Low-voltage control register fields and reset value.
   localparam int         RSD_LVC_CSS_BIT = 5;
   localparam int         RSD_LVC_LVL_BIT = 3;
   localparam logic [7:0] RSD_LVC_RST     = 8'h08;

   // Watchdog control/status field positions.
   localparam int         RSD_WD_B6WI     = 7;
   localparam int         RSD_WD_TCWE     = 6;
   localparam int         RSD_WD_B4WI     = 5;
   localparam int         RSD_WD_CSWE     = 4;
   localparam int         RSD_WD_B2WI     = 3;
   localparam int         RSD_WD_ON       = 2;
   localparam int         RSD_WD_B0WI     = 1;
   localparam int         RSD_WD_RST      = 0;

   // Watchdog values after reset, counter maximum and the 8192 clock select code.
   localparam logic       RSD_WD_TCWE_RST = 1'b0;
   localparam logic       RSD_WD_CSWE_RST = 1'b0;
   localparam logic       RSD_WD_ON_RST   = 1'b1;
   localparam logic [7:0] RSD_WDCNT_RST   = 8'h00;
   localparam logic [7:0] RSD_WDCNT_MAX   = 8'hFF;
   localparam logic [3:0] RSD_WDCKS_RST   = 4'hF;
   localparam logic [3:0] RSD_WDCKS_8192  = 4'hF;

   // Counter widths and cycle counts.
   localparam int         RSD_PSC_W       = 13;
   localparam int         RSD_REL_W       = 18;
   localparam int         RSD_REL_STATES  = 131072;
   localparam int         RSD_WDT_DIV     = 8192;
   localparam logic [4:0] RSD_WDT_HOLD    = 5'h0F;

   // Internal reset state, naming what holds the reset.
   typedef enum logic [1:0] {
      RSD_RUN      = 2'b00,
      RSD_HOLD_EXT = 2'b01,
      RSD_HOLD_LV  = 2'b10,
      RSD_HOLD_WDT = 2'b11
   } rsd_state_t;
endpackage
`default_nettype wire

// >>> rtl/rsd_release_timer.sv
// Prescaler and release counter for power-on and low-voltage reset.
`default_nettype none
module rsd_release_timer #(
   parameter int REL_STATES = rsd_pkg::RSD_REL_STATES
) (
   // Clock and reset.
   input  wire logic                         clock,
   input  wire logic                         rst,
   // Supply condition.
   input  wire logic                         restart,
   // Status.
   output logic [rsd_pkg::RSD_PSC_W-1:0]     prescaler,
   output logic                              done
);
   logic [rsd_pkg::RSD_REL_W-1:0] elapsed_r;
   logic                          done_r;

   always_ff @(posedge clock) begin
      if (rst || restart) begin
         elapsed_r <= '0;
      end else begin
         elapsed_r <= elapsed_r + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || restart) begin
         done_r <= 1'b0;
      end else if (elapsed_r == rsd_pkg::RSD_REL_W'(REL_STATES - 1)) begin
         done_r <= 1'b1;
      end
   end

   assign prescaler = elapsed_r[rsd_pkg::RSD_PSC_W-1:0];
   assign done      = done_r;
endmodule // rsd_release_timer
`default_nettype wire

// >>> rtl/rsd_watchdog.sv
// Watchdog counter with its write-gated control/status register.
`default_nettype none
module rsd_watchdog (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Reset events.
   input  wire logic        wd_init,
   input  wire logic        ext_clear,
   // Count tick.
   input  wire logic        tick,
   // Register writes.
   input  wire logic        wr_cs,
   input  wire logic        wr_cnt,
   input  wire logic [7:0]  wdata,
   // State.
   output logic [7:0]       cs_value,
   output logic [7:0]       cnt_value,
   output logic             overflow
);
   logic       tcwe_r;
   logic       cswe_r;
   logic       on_r;
   logic       watchdog_reset_flag_r;
   logic [7:0] cnt_r;
   logic       ovf_r;
   logic       wr_cnt_ok;

   assign wr_cnt_ok = wr_cnt && tcwe_r;

   always_ff @(posedge clock) begin
      if (rst || wd_init) begin
         tcwe_r <= rsd_pkg::RSD_WD_TCWE_RST;
         cswe_r <= rsd_pkg::RSD_WD_CSWE_RST;
         on_r   <= rsd_pkg::RSD_WD_ON_RST;
      end else if (wr_cs) begin
         if (!wdata[rsd_pkg::RSD_WD_B6WI]) begin
            tcwe_r <= wdata[rsd_pkg::RSD_WD_TCWE];
         end
         if (!wdata[rsd_pkg::RSD_WD_B4WI]) begin
            cswe_r <= wdata[rsd_pkg::RSD_WD_CSWE];
         end
         if (!wdata[rsd_pkg::RSD_WD_B2WI] && cswe_r) begin
            on_r <= wdata[rsd_pkg::RSD_WD_ON];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst || ext_clear) begin
         watchdog_reset_flag_r <= 1'b0;
      end else if (ovf_r) begin
         watchdog_reset_flag_r <= 1'b1;
      end else if (wr_cs && cswe_r && !wdata[rsd_pkg::RSD_WD_B0WI]) begin
         watchdog_reset_flag_r <= wdata[rsd_pkg::RSD_WD_RST];
      end
   end

   always_ff @(posedge clock) begin
      if (rst || wd_init) begin
         cnt_r <= rsd_pkg::RSD_WDCNT_RST;
      end else if (wr_cnt_ok) begin
         cnt_r <= wdata;
      end else if (tick && on_r) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || wd_init) begin
         ovf_r <= 1'b0;
      end else begin
         ovf_r <= !wr_cnt_ok && tick && on_r && (cnt_r == rsd_pkg::RSD_WDCNT_MAX);
      end
   end

   assign cs_value  = {1'b1, tcwe_r, 1'b1, cswe_r, 1'b1, on_r, 1'b1, watchdog_reset_flag_r};
   assign cnt_value = cnt_r;
   assign overflow  = ovf_r;
endmodule // rsd_watchdog
`default_nettype wire

// >>> rtl/rsd_top.sv
// Reset generation and reset source recording with a watchdog.
`default_nettype none
module rsd_top #(
   parameter int REL_STATES = rsd_pkg::RSD_REL_STATES,
   parameter int WDT_DIV    = rsd_pkg::RSD_WDT_DIV
) (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Analog and pin inputs, asynchronous.
   input  wire logic        poweron_active,
   input  wire logic        supply_low,
   input  wire logic        external_reset_n,
   // Register port.
   input  wire logic [2:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Reset and detector control.
   output logic             internal_reset,
   output logic             detect_level_select,
   output logic             comparison_source_select
);
   localparam int NSYNC = 3;
   localparam logic [NSYNC-1:0] SYNC_IDLE = 3'h1;

   logic [NSYNC-1:0]           sync_in;
   logic [NSYNC-1:0]           sync1_r;
   logic [NSYNC-1:0]           sync2_r;
   logic                       por_s;
   logic                       low_s;
   logic                       pin_s;
   logic                       lv_cond;

   rsd_pkg::rsd_state_t        state_r;
   rsd_pkg::rsd_state_t        state_nxt;
   logic                       internal_reset_r;
   logic [4:0]                 hold_r;

   logic [rsd_pkg::RSD_PSC_W-1:0] prescaler;
   logic                       rel_done;
   logic                       wd_tick_nxt;
   logic                       wd_tick_r;
   logic [7:0]                 wd_cs;
   logic [7:0]                 wd_cnt;
   logic                       wd_ovf;
   logic                       ext_event;

   logic                       poweron_lowvolt_flag_r;
   logic                       watchdog_reset_flag_r;
   logic [7:0]                 lvc_r;
   logic [3:0]                 cks_r;
   logic [7:0]                 rdata_r;

   assign sync_in = {poweron_active, supply_low, external_reset_n};

   // all three inputs synchronised alike
   // Two-stage synchronisers start at each input's idle level.
   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         always_ff @(posedge clock) begin
            if (rst) begin
               sync1_r[i] <= SYNC_IDLE[i];
               sync2_r[i] <= SYNC_IDLE[i];
            end else begin
               sync1_r[i] <= sync_in[i];
               sync2_r[i] <= sync1_r[i];
            end
         end
      end
   endgenerate

   assign por_s   = sync2_r[2];
   assign low_s   = sync2_r[1];
   assign pin_s   = sync2_r[0];
   assign lv_cond = por_s || low_s;

   // Write decode used by several registers.
   function automatic logic wr_hit(input logic [2:0] ofs);
      return reg_wr && (reg_addr == ofs);
   endfunction

   rsd_release_timer #(
      .REL_STATES (REL_STATES)
   ) u_release (
      .clock      (clock),
      .rst        (rst),
      .restart    (lv_cond),
      .prescaler  (prescaler),
      .done       (rel_done)
   );

   localparam logic [rsd_pkg::RSD_PSC_W-1:0] RSD_PSC_MASK =
      rsd_pkg::RSD_PSC_W'(WDT_DIV - 1);

   assign wd_tick_nxt = (cks_r == rsd_pkg::RSD_WDCKS_8192)
                        && ((prescaler & RSD_PSC_MASK) == RSD_PSC_MASK);

   // Tick registered so the counter sees a strobe straight from a flip-flop.
   always_ff @(posedge clock) begin
      if (rst) begin
         wd_tick_r <= 1'b0;
      end else begin
         wd_tick_r <= wd_tick_nxt;
      end
   end

   rsd_watchdog u_watchdog (
      .clock      (clock),
      .rst        (rst),
      .wd_init    (internal_reset_r),
      .ext_clear  (ext_event),
      .tick       (wd_tick_r),
      .wr_cs      (wr_hit(rsd_pkg::RSD_OFS_WDCS)),
      .wr_cnt     (wr_hit(rsd_pkg::RSD_OFS_WDCNT)),
      .wdata      (reg_wdata),
      .cs_value   (wd_cs),
      .cnt_value  (wd_cnt),
      .overflow   (wd_ovf)
   );

   // Next reset state; supply events outrank the pin.
   always_comb begin
      state_nxt = state_r;
      if (lv_cond) begin
         state_nxt = rsd_pkg::RSD_HOLD_LV;
      end else if (!pin_s && state_r != rsd_pkg::RSD_HOLD_LV) begin
         state_nxt = rsd_pkg::RSD_HOLD_EXT;
      end else begin
         case (state_r)
            rsd_pkg::RSD_RUN: begin
               if (wd_ovf) begin
                  state_nxt = rsd_pkg::RSD_HOLD_WDT;
               end
            end
            rsd_pkg::RSD_HOLD_LV: begin
               if (rel_done) begin
                  state_nxt = rsd_pkg::RSD_RUN;
               end
            end
            rsd_pkg::RSD_HOLD_EXT: begin
               if (pin_s) begin
                  state_nxt = rsd_pkg::RSD_RUN;
               end
            end
            rsd_pkg::RSD_HOLD_WDT: begin
               if (hold_r == rsd_pkg::RSD_WDT_HOLD) begin
                  state_nxt = rsd_pkg::RSD_RUN;
               end
            end
            default: begin
               state_nxt = rsd_pkg::RSD_HOLD_LV;
            end
         endcase
      end
   end

   assign ext_event = (state_nxt == rsd_pkg::RSD_HOLD_EXT)
                      && (state_r != rsd_pkg::RSD_HOLD_EXT);

   // three reset causes plus run held
   // Reset state register; a cold reset counts as power-on.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= rsd_pkg::RSD_HOLD_LV;
      end else begin
         state_r <= state_nxt;
      end
   end

   // reset output registered
   // Internal reset output from a flip-flop.
   always_ff @(posedge clock) begin
      if (rst) begin
         internal_reset_r <= 1'b1;
      end else begin
         internal_reset_r <= (state_nxt != rsd_pkg::RSD_RUN);
      end
   end

   // Length of the watchdog-caused reset pulse.
   always_ff @(posedge clock) begin
      if (rst || state_r != rsd_pkg::RSD_HOLD_WDT) begin
         hold_r <= 5'h00;
      end else begin
         hold_r <= hold_r + 5'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         poweron_lowvolt_flag_r <= 1'b1;
      end else if (lv_cond) begin
         poweron_lowvolt_flag_r <= 1'b1;
      end else if (wr_hit(rsd_pkg::RSD_OFS_CAUSE) && !reg_wdata[rsd_pkg::RSD_POWERON_LOWVOLT_FLAG_BIT]) begin
         poweron_lowvolt_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         watchdog_reset_flag_r <= 1'b0;
      end else if (wd_ovf) begin
         watchdog_reset_flag_r <= 1'b1;
      end else if (lv_cond || ext_event) begin
         watchdog_reset_flag_r <= 1'b0;
      end else if (wr_hit(rsd_pkg::RSD_OFS_CAUSE) && !reg_wdata[rsd_pkg::RSD_WATCHDOG_RESET_FLAG_BIT]) begin
         watchdog_reset_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         lvc_r <= rsd_pkg::RSD_LVC_RST;
      end else if (wr_hit(rsd_pkg::RSD_OFS_LVCTRL)) begin
         lvc_r <= '0;
         lvc_r[rsd_pkg::RSD_LVC_CSS_BIT] <= reg_wdata[rsd_pkg::RSD_LVC_CSS_BIT];
         lvc_r[rsd_pkg::RSD_LVC_LVL_BIT] <= reg_wdata[rsd_pkg::RSD_LVC_LVL_BIT];
      end
   end

   // clock select register
   // Watchdog clock select register.
   always_ff @(posedge clock) begin
      if (rst || internal_reset_r) begin
         cks_r <= rsd_pkg::RSD_WDCKS_RST;
      end else if (wr_hit(rsd_pkg::RSD_OFS_WDCKS)) begin
         cks_r <= reg_wdata[3:0];
      end
   end

   // Value of one register offset; unmapped offsets read zero.
   function automatic logic [7:0] read_word(input logic [2:0] ofs);
      case (ofs)
         rsd_pkg::RSD_OFS_CAUSE:  return {6'h00, poweron_lowvolt_flag_r, watchdog_reset_flag_r};
         rsd_pkg::RSD_OFS_LVCTRL: return lvc_r;
         rsd_pkg::RSD_OFS_WDCS:   return wd_cs;
         rsd_pkg::RSD_OFS_WDCNT:  return wd_cnt;
         rsd_pkg::RSD_OFS_WDCKS:  return {4'h0, cks_r};
         default:                 return 8'h00;
      endcase
   endfunction

   // Read data one cycle after the strobe, zero otherwise.
   always_ff @(posedge clock) begin
      if (rst || !reg_rd) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= read_word(reg_addr);
      end
   end

   assign reg_rdata                = rdata_r;
   assign internal_reset           = internal_reset_r;
   assign detect_level_select      = lvc_r[rsd_pkg::RSD_LVC_LVL_BIT];
   assign comparison_source_select = lvc_r[rsd_pkg::RSD_LVC_CSS_BIT];
endmodule // rsd_top
`default_nettype wire

// >>> test/rsd_top_checker.sv
// Concurrent assertions on the ports of the reset source detection block.
`default_nettype none
module rsd_top_checker #(
   parameter int REL_STATES = rsd_pkg::RSD_REL_STATES
) (
   // Clock and reset.
   input wire logic       clock,
   input wire logic       rst,
   // Analog and pin inputs.
   input wire logic       poweron_active,
   input wire logic       supply_low,
   input wire logic       external_reset_n,
   // Register port.
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Outputs.
   input wire logic       internal_reset,
   input wire logic       detect_level_select,
   input wire logic       comparison_source_select
);
   timeunit 1ns;
   timeprecision 1ps;
   int calm_r;

   // Counts cycles since the supply was last low or just applied.
   always_ff @(posedge clock) begin
      if (rst || poweron_active || supply_low) begin
         calm_r <= 0;
      end else if (calm_r < 1000000) begin
         calm_r <= calm_r + 1;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   chk_rel_wait: assert property (
      !internal_reset && !supply_low && !poweron_active |-> calm_r >= REL_STATES)
      else $error("internal reset released early");
   chk_lv_hold: assert property (
      supply_low [*5] |-> internal_reset)
      else $error("low supply without internal reset");
   chk_por_hold: assert property (
      poweron_active [*5] |-> internal_reset)
      else $error("power-on without internal reset");
   chk_pin_hold: assert property (
      !external_reset_n [*5] |-> internal_reset)
      else $error("low pin without internal reset");
   chk_wd_hold: assert property (
      $rose(internal_reset) && external_reset_n && calm_r > 8 |-> internal_reset [*8])
      else $error("watchdog reset too short");
   chk_rd_idle: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   chk_unmapped: assert property (
      reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_cause_rsvd: assert property (
      reg_rd && reg_addr == rsd_pkg::RSD_OFS_CAUSE |=> reg_rdata[7:2] == 6'h00)
      else $error("reserved flag bits not zero");
   chk_wdcs_ones: assert property (
      reg_rd && reg_addr == rsd_pkg::RSD_OFS_WDCS |=> (reg_rdata & 8'hAA) == 8'hAA)
      else $error("write disable bits not one");
   chk_lvc_pins: assert property (
      reg_wr && reg_addr == rsd_pkg::RSD_OFS_LVCTRL && !internal_reset ##1 !reg_wr
      |=> {2'b00, comparison_source_select, 1'b0, detect_level_select, 3'b000}
          == ($past(reg_wdata, 2) & 8'h28))
      else $error("control outputs do not follow register");
endmodule // rsd_top_checker

bind rsd_top rsd_top_checker #(.REL_STATES(REL_STATES)) u_chk (
   .clock, .rst, .poweron_active, .supply_low, .external_reset_n,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .internal_reset, .detect_level_select, .comparison_source_select
);
`default_nettype wire

// >>> test/rsd_board_reset.sv
// Board reset circuit model driving the external reset pin.
`default_nettype none
module rsd_board_reset #(
   parameter int LOW_CYCLES = 20
) (
   // Clock.
   input  wire logic clock,
   // Request from the bench.
   input  wire logic press,
   // Reset pin.
   output var logic  external_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int left_r = 0;
   initial external_reset_n = 1'b1;

   always @(posedge clock) begin
      if (press && left_r == 0) begin
         left_r <= LOW_CYCLES;
      end else if (left_r > 0) begin
         left_r <= left_r - 1;
      end
      external_reset_n <= !(press || left_r > 1);
   end
endmodule // rsd_board_reset
`default_nettype wire

// >>> test/rsd_top_test.sv
// Self-checking testbench for the reset source detection block.
`default_nettype none
module rsd_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REL = 64;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       poweron_active = 1'b0;
   logic       supply_low = 1'b0;
   logic       press = 1'b0;
   wire logic  external_reset_n;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic       internal_reset;
   logic       detect_level_select;
   logic       comparison_source_select;
   int         errors = 0;
   int         tests_run = 0;
   int         n;
   int         cyc = 0;
   int         t0;

   always #4 clock = !clock;
   always @(posedge clock) cyc <= cyc + 1;

   rsd_top #(.REL_STATES(REL), .WDT_DIV(16)) DUT (
      .clock, .rst, .poweron_active, .supply_low, .external_reset_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .internal_reset, .detect_level_select, .comparison_source_select
   );

   rsd_board_reset u_board (.clock, .press, .external_reset_n);

   task automatic test_done;
      if (errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      check($sformatf("register %0d", a), exp, reg_rdata);
      @(posedge clock);
   endtask

   task automatic wait_ir(input logic v, input int lim);
      n = 0;
      while (internal_reset !== v && n < lim) begin
         @(posedge clock);
         n++;
      end
      check("internal_reset", {7'h00, v}, {7'h00, internal_reset});
   endtask

   initial begin
      #200000;
      errors++;
      test_done;
   end

   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      wait_ir(1'b0, 200);
      check("power-on hold", 8'h01, 8'(n >= REL));
      t0 = cyc;
      rd(rsd_pkg::RSD_OFS_CAUSE, rsd_pkg::RSD_CAUSE_PWR);
      rd(rsd_pkg::RSD_OFS_LVCTRL, rsd_pkg::RSD_LVC_RST);
      rd(rsd_pkg::RSD_OFS_WDCS, 8'hAE);
      rd(rsd_pkg::RSD_OFS_WDCKS, {4'h0, rsd_pkg::RSD_WDCKS_RST});
      rd(3'h6, 8'h00);
      wr(rsd_pkg::RSD_OFS_CAUSE, 8'hFF);
      rd(rsd_pkg::RSD_OFS_CAUSE, rsd_pkg::RSD_CAUSE_PWR);
      wr(rsd_pkg::RSD_OFS_CAUSE, 8'h00);
      rd(rsd_pkg::RSD_OFS_CAUSE, rsd_pkg::RSD_CAUSE_EXT);
      wr(rsd_pkg::RSD_OFS_LVCTRL, 8'hFF);
      rd(rsd_pkg::RSD_OFS_LVCTRL, 8'h28);
      check("selects", 8'h03, {6'h00, comparison_source_select, detect_level_select});
      wr(rsd_pkg::RSD_OFS_LVCTRL, 8'h08);
      rd(rsd_pkg::RSD_OFS_LVCTRL, 8'h08);
      check("selects", 8'h01, {6'h00, comparison_source_select, detect_level_select});
      wait_ir(1'b1, 5000);
      check("watchdog period", 8'h01, 8'(cyc - t0 >= 4080 && cyc - t0 <= 4120));
      wait_ir(1'b0, 40);
      rd(rsd_pkg::RSD_OFS_CAUSE, rsd_pkg::RSD_CAUSE_WDT);
      rd(rsd_pkg::RSD_OFS_WDCS, 8'hAF);
      wr(rsd_pkg::RSD_OFS_WDCS, 8'hA2);
      rd(rsd_pkg::RSD_OFS_WDCS, 8'hAF);
      wr(rsd_pkg::RSD_OFS_WDCS, 8'h1A);
      wr(rsd_pkg::RSD_OFS_WDCS, 8'hA2);
      wr(rsd_pkg::RSD_OFS_WDCS, 8'h6A);
      wr(rsd_pkg::RSD_OFS_WDCNT, 8'hFE);
      rd(rsd_pkg::RSD_OFS_WDCNT, 8'hFE);
      rd(rsd_pkg::RSD_OFS_WDCS, 8'hFB);
      wr(rsd_pkg::RSD_OFS_WDCS, 8'hA6);
      wait_ir(1'b1, 60);
      wait_ir(1'b0, 40);
      rd(rsd_pkg::RSD_OFS_WDCNT, rsd_pkg::RSD_WDCNT_RST);
      rd(rsd_pkg::RSD_OFS_CAUSE, rsd_pkg::RSD_CAUSE_WDT);
      press <= 1'b1;
      @(posedge clock);
      press <= 1'b0;
      wait_ir(1'b1, 10);
      wait_ir(1'b0, 40);
      rd(rsd_pkg::RSD_OFS_CAUSE, rsd_pkg::RSD_CAUSE_EXT);
      rd(rsd_pkg::RSD_OFS_WDCS, 8'hAE);
      for (int k = 0; k < 2; k++) begin
         wr(rsd_pkg::RSD_OFS_CAUSE, 8'h00);
         {poweron_active, supply_low} <= 2'(k + 1);
         repeat (10) @(posedge clock);
         check("internal_reset", 8'h01, {7'h00, internal_reset});
         {poweron_active, supply_low} <= 2'b00;
         wait_ir(1'b0, 200);
         check("release delay", 8'h01, 8'(n >= REL));
         rd(rsd_pkg::RSD_OFS_CAUSE, rsd_pkg::RSD_CAUSE_PWR);
      end
      test_done;
   end
endmodule // rsd_top_test
`default_nettype wire
